// >>> src/iqs_pkg.sv
// package: register map, field layout, reset values and carrier types for the first interrupt bank
package iqs_pkg;
    // word offsets as printed (register index on the control interface)
    localparam logic [15:0] ADDR_STATUS3   = 16'h0D02;
    localparam logic [15:0] ADDR_STATUS4   = 16'h0D03;
    localparam logic [15:0] ADDR_STATUS5   = 16'h0D04;
    localparam logic [15:0] ADDR_MASK_BASE = 16'h0D08;
    localparam logic [15:0] ADDR_MASK3     = 16'h0D0A;
    localparam logic [15:0] ADDR_MASK4     = 16'h0D0B;
    localparam logic [15:0] ADDR_MASK5     = 16'h0D0C;
    localparam logic [15:0] ADDR_CONTROL   = 16'h0D0F;
    localparam logic [15:0] ADDR_AOD_FLAGS = 16'h0D51;
    localparam logic [15:0] ADDR_AOD_MASK  = 16'h0D53;
    localparam logic [15:0] ADDR_OUT_CTRL  = 16'h0C0F;

    // implemented bits of each status word
    localparam logic [15:0] IMPL_STATUS3 = 16'h000F;
    localparam logic [15:0] IMPL_STATUS4 = 16'hFFC0;
    localparam logic [15:0] IMPL_STATUS5 = 16'h01C3;
    localparam logic [15:0] IMPL_AOD     = 16'h00FC;

    // mask resets: everything masked except the boot-complete source
    localparam logic [15:0] MASK3_RESET    = 16'hFFFF;
    localparam logic [15:0] MASK4_RESET    = 16'hFFFF;
    localparam logic [15:0] MASK5_RESET    = 16'hFEFF;
    localparam logic [15:0] AOD_MASK_RESET = 16'hFFFF;
    localparam logic [15:0] CONTROL_RESET  = 16'h0000;

    // field positions
    localparam int GLOBAL_MASK_BIT = 0;
    localparam int POLARITY_BIT    = 10;
    localparam logic POLARITY_RESET = 1'b1;

    // status-three bits
    localparam int S3_PLL2_LOCK  = 3;
    localparam int S3_PLL1_LOCK  = 2;
    localparam int S3_SYS_UNDER  = 1;
    localparam int S3_ASYNC_UNDER = 0;
    // status-five bits
    localparam int S5_BOOT     = 8;
    localparam int S5_DAC_SRV  = 7;
    localparam int S5_HP_SRV   = 6;
    localparam int S5_PLL2_OK  = 1;
    localparam int S5_PLL1_OK  = 0;

    // raw event levels from the rest of the device
    typedef struct packed {
        logic       pll2Lock;
        logic       pll1Lock;
        logic       sysUnderclock;
        logic       asyncUnderclock;
        logic       asyncRateCfgErr;
        logic [2:0] audioPortErr;   // [2]=port3 [1]=port2 [0]=port1
        logic       hostIfErr;
        logic       mixerDrop;
        logic       asyncClockEna;
        logic       sysClockEna;
        logic       isoRate1CfgErr;
        logic       isoRate2CfgErr;
        logic       bootDone;
        logic       dacServoDone;
        logic       hpServoDone;
        logic       pll2ClockGood;
        logic       pll1ClockGood;
        logic       micClamp;
        logic       pin5;
        logic       jackDetect;
    } iqs_events_type;

    // register access strobe from the control interface
    typedef struct packed {
        logic        wrEn;
        logic        rdEn;
        logic [15:0] addr;
        logic [15:0] wdata;
    } iqs_req_type;

    typedef struct packed {
        logic [15:0] s3;
        logic [15:0] s4;
        logic [15:0] s5;
        logic [15:0] aod;
    } iqs_words_type;
endpackage

// >>> src/iqs_edge_sampler.sv
// event sampler: registers raw levels and reports per-flag set requests
`timescale 1ns/1ps
module iqs_edge_sampler (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstSyncN,
    // raw levels
    input  wire iqs_pkg::iqs_events_type evIn,
    // set requests, one cycle per qualifying transition
    output iqs_pkg::iqs_words_type       setReq
);
    iqs_pkg::iqs_events_type curR, curNxt, prevR, prevNxt;
    logic                    primedR, primedNxt;

    function automatic logic rise(input logic c, input logic p);
        return c & ~p;
    endfunction
    function automatic logic fall(input logic c, input logic p);
        return ~c & p;
    endfunction

    always_comb begin
        curNxt    = evIn;
        // first sample after reset seeds both stages, so a level already high is no edge
        prevNxt   = primedR ? curR : evIn;
        primedNxt = 1'b1;
    end

    // reset to zero levels; primed blocks a false edge from the reset image
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            curR    <= '0;
            prevR   <= '0;
            primedR <= 1'b0;
        end else begin
            curR    <= curNxt;
            prevR   <= prevNxt;
            primedR <= primedNxt;
        end
    end

    always_comb begin
        setReq = '0;
        if (primedR) begin
            setReq.s3[iqs_pkg::S3_PLL2_LOCK]   = curR.pll2Lock ^ prevR.pll2Lock;
            setReq.s3[iqs_pkg::S3_PLL1_LOCK]   = curR.pll1Lock ^ prevR.pll1Lock;
            setReq.s3[iqs_pkg::S3_SYS_UNDER]   = rise(curR.sysUnderclock, prevR.sysUnderclock);
            setReq.s3[iqs_pkg::S3_ASYNC_UNDER] = rise(curR.asyncUnderclock, prevR.asyncUnderclock);
            setReq.s4[15]    = rise(curR.asyncRateCfgErr, prevR.asyncRateCfgErr);
            setReq.s4[14:12] = curR.audioPortErr & ~prevR.audioPortErr;
            setReq.s4[11]    = rise(curR.hostIfErr, prevR.hostIfErr);
            setReq.s4[10]    = rise(curR.mixerDrop, prevR.mixerDrop);
            setReq.s4[9]     = fall(curR.asyncClockEna, prevR.asyncClockEna);
            setReq.s4[8]     = fall(curR.sysClockEna, prevR.sysClockEna);
            setReq.s4[7]     = rise(curR.isoRate1CfgErr, prevR.isoRate1CfgErr);
            setReq.s4[6]     = rise(curR.isoRate2CfgErr, prevR.isoRate2CfgErr);
            setReq.s5[iqs_pkg::S5_BOOT]    = rise(curR.bootDone, prevR.bootDone);
            setReq.s5[iqs_pkg::S5_DAC_SRV] = rise(curR.dacServoDone, prevR.dacServoDone);
            setReq.s5[iqs_pkg::S5_HP_SRV]  = rise(curR.hpServoDone, prevR.hpServoDone);
            setReq.s5[iqs_pkg::S5_PLL2_OK] = curR.pll2ClockGood ^ prevR.pll2ClockGood;
            setReq.s5[iqs_pkg::S5_PLL1_OK] = curR.pll1ClockGood ^ prevR.pll1ClockGood;
            setReq.aod[7] = fall(curR.micClamp, prevR.micClamp);
            setReq.aod[6] = rise(curR.micClamp, prevR.micClamp);
            setReq.aod[5] = fall(curR.pin5, prevR.pin5);
            setReq.aod[4] = rise(curR.pin5, prevR.pin5);
            setReq.aod[3] = fall(curR.jackDetect, prevR.jackDetect);
            setReq.aod[2] = rise(curR.jackDetect, prevR.jackDetect);
        end
    end

    property p_rise_once;
        @(posedge clk) disable iff (!rstSyncN)
        setReq.s5[iqs_pkg::S5_BOOT] |=> !setReq.s5[iqs_pkg::S5_BOOT];
    endproperty
    a_rise_once: assert property (p_rise_once) else $error("boot set request lasted more than one cycle");

    property p_pin5_excl;
        @(posedge clk) disable iff (!rstSyncN)
        !(setReq.aod[5] && setReq.aod[4]);
    endproperty
    a_pin5_excl: assert property (p_pin5_excl) else $error("pin5 rise and fall requested together");

    // levels standing at reset release must not look like transitions
    property p_seed_quiet;
        @(posedge clk) disable iff (!rstSyncN)
        $rose(primedR) |-> (setReq == '0);
    endproperty
    a_seed_quiet: assert property (p_seed_quiet) else $error("set request right after reset release");
endmodule // iqs_edge_sampler

// >>> src/iqs_irq_status.sv
// first interrupt bank: latching flags, masks, global mask and request pin
`timescale 1ns/1ps
// Operation
// - flags stick until host writes one
// - pll lock flags set on both edges
// - system underclock flag on rising edge
// - async underclock flag on rising edge
// - async rate config error on rising edge
// - audio port errors on rising edges
// - host interface error on rising edge
// - mixer drop on rising edge
// - clock-off flags on enable shut-down
// - iso rate config errors on rising edges
// - boot complete on rising edge
// - dac servo done on rising edge
// - headphone servo done on rising edge
// - pll clock-good flags on both edges
// - one mask bit per flag position
// - mask zero passes, one blocks
// - only boot mask resets unmasked
// - global mask bit zero, resets clear
// - always-on rise and fall flags
// - pin5 flags follow their own edge
// - always-on masks reset to one
// - request is OR of unmasked flags
// - pin active low, polarity bit ten
module iqs_irq_status (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    resetn,
    // control interface register access
    input  wire iqs_pkg::iqs_req_type    hostReq,
    output logic [15:0]                  rdData_r,
    output logic                         rdValid_r,
    // event sources
    input  wire iqs_pkg::iqs_events_type evIn,
    // request outputs
    output logic                         request_out_first_r,
    output logic                         irqPin_r
);
    logic                   rstSync1R, rstSyncN;
    iqs_pkg::iqs_words_type setReq;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rstSync1R <= 1'b0;
            rstSyncN  <= 1'b0;
        end else begin
            rstSync1R <= 1'b1;
            rstSyncN  <= rstSync1R;
        end
    end

    iqs_edge_sampler u_sampler (
        .clk      (core_clk),
        .rstSyncN (rstSyncN),
        .evIn     (evIn),
        .setReq   (setReq)
    );

    iqs_pkg::iqs_words_type flags_r, flags_nxt;
    logic [15:0] mask3_r, mask3_nxt, mask4_r, mask4_nxt, mask5_r, mask5_nxt;
    logic [15:0] aodMask_r, aodMask_nxt;
    logic        globalMask_r, globalMask_nxt;
    logic        polarity_r, polarity_nxt;
    logic [15:0] rdData_nxt;
    logic        rdValid_nxt;
    logic        reqOut_nxt, irqPin_nxt;

    function automatic logic hit(input iqs_pkg::iqs_req_type r, input logic [15:0] a);
        return r.wrEn && (r.addr == a);
    endfunction

    // set wins over a same-cycle clear so no event is lost
    function automatic logic [15:0] w1c(input logic [15:0] cur, input logic [15:0] set,
                                        input logic [15:0] clr, input logic [15:0] impl);
        return ((cur & ~clr) | set) & impl;
    endfunction

    always_comb begin
        logic [15:0] c3, c4, c5, ca;
        c3 = hit(hostReq, iqs_pkg::ADDR_STATUS3)   ? hostReq.wdata : 16'h0000;
        c4 = hit(hostReq, iqs_pkg::ADDR_STATUS4)   ? hostReq.wdata : 16'h0000;
        c5 = hit(hostReq, iqs_pkg::ADDR_STATUS5)   ? hostReq.wdata : 16'h0000;
        ca = hit(hostReq, iqs_pkg::ADDR_AOD_FLAGS) ? hostReq.wdata : 16'h0000;
        flags_nxt.s3  = w1c(flags_r.s3, setReq.s3, c3, iqs_pkg::IMPL_STATUS3);
        flags_nxt.s4  = w1c(flags_r.s4, setReq.s4, c4, iqs_pkg::IMPL_STATUS4);
        flags_nxt.s5  = w1c(flags_r.s5, setReq.s5, c5, iqs_pkg::IMPL_STATUS5);
        flags_nxt.aod = w1c(flags_r.aod, setReq.aod, ca, iqs_pkg::IMPL_AOD);
    end

    always_comb begin
        mask3_nxt      = hit(hostReq, iqs_pkg::ADDR_MASK3) ? hostReq.wdata : mask3_r;
        mask4_nxt      = hit(hostReq, iqs_pkg::ADDR_MASK4) ? hostReq.wdata : mask4_r;
        mask5_nxt      = hit(hostReq, iqs_pkg::ADDR_MASK5) ? hostReq.wdata : mask5_r;
        aodMask_nxt    = hit(hostReq, iqs_pkg::ADDR_AOD_MASK) ? hostReq.wdata : aodMask_r;
        globalMask_nxt = hit(hostReq, iqs_pkg::ADDR_CONTROL)
                       ? hostReq.wdata[iqs_pkg::GLOBAL_MASK_BIT] : globalMask_r;
        polarity_nxt   = hit(hostReq, iqs_pkg::ADDR_OUT_CTRL)
                       ? hostReq.wdata[iqs_pkg::POLARITY_BIT] : polarity_r;
    end

    always_comb begin
        rdValid_nxt = hostReq.rdEn;
        rdData_nxt  = 16'h0000;
        if (hostReq.rdEn) begin
            unique case (hostReq.addr)
                iqs_pkg::ADDR_STATUS3:   rdData_nxt = flags_r.s3;
                iqs_pkg::ADDR_STATUS4:   rdData_nxt = flags_r.s4;
                iqs_pkg::ADDR_STATUS5:   rdData_nxt = flags_r.s5;
                iqs_pkg::ADDR_MASK3:     rdData_nxt = mask3_r;
                iqs_pkg::ADDR_MASK4:     rdData_nxt = mask4_r;
                iqs_pkg::ADDR_MASK5:     rdData_nxt = mask5_r;
                iqs_pkg::ADDR_CONTROL:   rdData_nxt = {15'h0000, globalMask_r};
                iqs_pkg::ADDR_AOD_FLAGS: rdData_nxt = flags_r.aod;
                iqs_pkg::ADDR_AOD_MASK:  rdData_nxt = aodMask_r;
                iqs_pkg::ADDR_OUT_CTRL:  rdData_nxt = {5'h00, polarity_r, 10'h000};
                default:                 rdData_nxt = 16'h0000;
            endcase
        end
    end

    // request follows flags of the same cycle, so it is one cycle behind the flag registers
    always_comb begin
        logic any;
        any = |(flags_r.s3 & ~mask3_r) | |(flags_r.s4 & ~mask4_r)
            | |(flags_r.s5 & ~mask5_r) | |(flags_r.aod & ~aodMask_r);
        reqOut_nxt = any & ~globalMask_r;
        irqPin_nxt = polarity_r ? ~reqOut_nxt : reqOut_nxt;
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            flags_r             <= '0;
            mask3_r             <= iqs_pkg::MASK3_RESET;
            mask4_r             <= iqs_pkg::MASK4_RESET;
            mask5_r             <= iqs_pkg::MASK5_RESET;
            aodMask_r           <= iqs_pkg::AOD_MASK_RESET;
            globalMask_r        <= iqs_pkg::CONTROL_RESET[0];
            polarity_r          <= iqs_pkg::POLARITY_RESET;
            rdData_r            <= 16'h0000;
            rdValid_r           <= 1'b0;
            request_out_first_r <= 1'b0;
            irqPin_r            <= iqs_pkg::POLARITY_RESET;
        end else begin
            flags_r             <= flags_nxt;
            mask3_r             <= mask3_nxt;
            mask4_r             <= mask4_nxt;
            mask5_r             <= mask5_nxt;
            aodMask_r           <= aodMask_nxt;
            globalMask_r        <= globalMask_nxt;
            polarity_r          <= polarity_nxt;
            rdData_r            <= rdData_nxt;
            rdValid_r           <= rdValid_nxt;
            request_out_first_r <= reqOut_nxt;
            irqPin_r            <= irqPin_nxt;
        end
    end

    // assertions
    property p_sticky;
        @(posedge core_clk) disable iff (!rstSyncN)
        (flags_r.s4[11] && !(hostReq.wrEn && hostReq.addr == iqs_pkg::ADDR_STATUS4 && hostReq.wdata[11]))
        |=> flags_r.s4[11];
    endproperty
    a_sticky: assert property (p_sticky) else $error("status flag dropped without a clear");

    property p_set_wins;
        @(posedge core_clk) disable iff (!rstSyncN)
        setReq.s3[iqs_pkg::S3_SYS_UNDER] |=> flags_r.s3[iqs_pkg::S3_SYS_UNDER];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

    property p_lock_fall;
        @(posedge core_clk) disable iff (!rstSyncN)
        $fell(evIn.pll1Lock) |-> ##3 flags_r.s3[iqs_pkg::S3_PLL1_LOCK];
    endproperty
    a_lock_fall: assert property (p_lock_fall) else $error("pll1 lock fall not flagged");

    property p_boot_flag;
        @(posedge core_clk) disable iff (!rstSyncN)
        $rose(evIn.bootDone) |-> ##2 flags_r.s5[iqs_pkg::S5_BOOT];
    endproperty
    a_boot_flag: assert property (p_boot_flag) else $error("boot done not flagged");

    property p_clkoff;
        @(posedge core_clk) disable iff (!rstSyncN)
        $fell(evIn.sysClockEna) |-> ##3 flags_r.s4[8];
    endproperty
    a_clkoff: assert property (p_clkoff) else $error("clock shut-down not flagged");

    property p_or_out;
        @(posedge core_clk) disable iff (!rstSyncN)
        (flags_r.s5[iqs_pkg::S5_BOOT] && !mask5_r[iqs_pkg::S5_BOOT] && !globalMask_r) |=> request_out_first_r;
    endproperty
    a_or_out: assert property (p_or_out) else $error("unmasked flag gave no request");

    property p_global;
        @(posedge core_clk) disable iff (!rstSyncN)
        globalMask_r |=> !request_out_first_r;
    endproperty
    a_global: assert property (p_global) else $error("global mask did not block request");

    property p_masked;
        @(posedge core_clk) disable iff (!rstSyncN)
        (flags_r == '0) |=> !request_out_first_r;
    endproperty
    a_masked: assert property (p_masked) else $error("request without any flag");

    property p_pin;
        @(posedge core_clk) disable iff (!rstSyncN)
        ##1 (irqPin_r == ($past(polarity_r) ? ~request_out_first_r : request_out_first_r));
    endproperty
    a_pin: assert property (p_pin) else $error("pin polarity wrong");

    property p_clear;
        @(posedge core_clk) disable iff (!rstSyncN)
        hit(hostReq, iqs_pkg::ADDR_STATUS4) && hostReq.wdata[11] && !setReq.s4[11] |=> !flags_r.s4[11];
    endproperty
    a_clear: assert property (p_clear) else $error("written one did not clear flag");

    property p_mask_read;
        @(posedge core_clk) disable iff (!rstSyncN)
        hostReq.rdEn && hostReq.addr == iqs_pkg::ADDR_MASK4 |=> rdData_r == $past(mask4_r);
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask word read back wrong");

    property p_hp_servo;
        @(posedge core_clk) disable iff (!rstSyncN)
        $rose(evIn.hpServoDone) |-> ##2 flags_r.s5[iqs_pkg::S5_HP_SRV];
    endproperty
    a_hp_servo: assert property (p_hp_servo) else $error("headphone servo done not flagged");

    property p_pin5_rise;
        @(posedge core_clk) disable iff (!rstSyncN)
        $rose(evIn.pin5) |-> ##2 flags_r.aod[4];
    endproperty
    a_pin5_rise: assert property (p_pin5_rise) else $error("pin5 rise not flagged");

    // always-on flags reach the request only through their own mask word
    property p_aod_out;
        @(posedge core_clk) disable iff (!rstSyncN)
        (flags_r.aod[4] && !aodMask_r[4] && !globalMask_r) |=> request_out_first_r;
    endproperty
    a_aod_out: assert property (p_aod_out) else $error("unmasked always-on flag gave no request");

    c_boot_irq:  cover property (@(posedge core_clk) disable iff (!rstSyncN)
        $rose(request_out_first_r) && flags_r.s5[iqs_pkg::S5_BOOT]);
    c_clear:     cover property (@(posedge core_clk) disable iff (!rstSyncN) $fell(request_out_first_r));
    c_aod_fall:  cover property (@(posedge core_clk) disable iff (!rstSyncN) setReq.aod[5]);
    c_pol_high:  cover property (@(posedge core_clk) disable iff (!rstSyncN) !polarity_r && irqPin_r);
    c_aod_irq:   cover property (@(posedge core_clk) disable iff (!rstSyncN)
        request_out_first_r && flags_r.aod[4] && !aodMask_r[4]);
endmodule // iqs_irq_status

// >>> testbench/iqs_host_model.sv
// host-side model: one-cycle register read and write strobes on the control interface
`timescale 1ns/1ps
module iqs_host_model (
    // clock
    input  wire logic             core_clk,
    // register access
    output iqs_pkg::iqs_req_type  hostReq,
    input  wire logic [15:0]      rdData_r,
    input  wire logic             rdValid_r
);
    initial hostReq = '0;

    // released address and data are inverted so a stale value can never look valid
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge core_clk);
        hostReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wdata: d};
        @(negedge core_clk);
        hostReq = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
        @(negedge core_clk);
        hostReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge core_clk);
        hostReq = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: 16'hFFFF};
        d = rdData_r;
        v = rdValid_r;
    endtask
endmodule // iqs_host_model

// >>> testbench/tb_iqs_irq_status.sv
// testbench for the first interrupt bank: event edge table, then masking, polarity and reset cases
`timescale 1ns/1ps
module tb_iqs_irq_status;
    typedef struct { int b; int w; logic [15:0] exp; } iqs_row_type;
    logic                    core_clk;
    logic                    resetn;
    iqs_pkg::iqs_req_type    hostReq;
    logic [15:0]             rdData_r;
    logic                    rdValid_r;
    iqs_pkg::iqs_events_type evIn;
    logic                    request_out_first_r;
    logic                    irqPin_r;
    logic                    pol;
    int                      fail_count;
    int                      check_count;
    logic [15:0]             words [4];
    iqs_row_type             rows [33];

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    iqs_irq_status dut (
        .core_clk            (core_clk),
        .resetn              (resetn),
        .hostReq             (hostReq),
        .rdData_r            (rdData_r),
        .rdValid_r           (rdValid_r),
        .evIn                (evIn),
        .request_out_first_r (request_out_first_r),
        .irqPin_r            (irqPin_r)
    );

    iqs_host_model host (
        .core_clk  (core_clk),
        .hostReq   (hostReq),
        .rdData_r  (rdData_r),
        .rdValid_r (rdValid_r)
    );

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic        v;
        host.rd(a, d, v);
        chk("rdValid_r", 16'h0001, {15'h0000, v});
        chk($sformatf("word %h", a), exp, d);
    endtask

    // request and pin are judged together; pin level follows the polarity we last wrote
    task automatic wait_req(input logic val);
        int n;
        n = 0;
        repeat (2) @(negedge core_clk);
        while (request_out_first_r !== val && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        chk("request_out_first_r", {15'h0000, val}, {15'h0000, request_out_first_r});
        chk("irqPin_r", {15'h0000, pol ? ~val : val}, {15'h0000, irqPin_r});
        if (request_out_first_r !== val) test_done();
    endtask

    task automatic do_reset();
        @(negedge core_clk);
        resetn = 1'b0;
        pol = 1'b1;
        repeat (8) @(negedge core_clk);
        chk("request_out_first_r", 16'h0000, {15'h0000, request_out_first_r});
        chk("irqPin_r", 16'h0001, {15'h0000, irqPin_r});
        resetn = 1'b1;
        repeat (5) @(negedge core_clk);
    endtask

    task automatic check_resets();
        host.wr(16'h0D05, 16'hFFFF);
        rdchk(16'h0D05, 16'h0000);
        foreach (words[i]) rdchk(words[i], 16'h0000);
        rdchk(iqs_pkg::ADDR_MASK3, 16'hFFFF);
        rdchk(iqs_pkg::ADDR_MASK4, 16'hFFFF);
        rdchk(iqs_pkg::ADDR_MASK5, 16'hFEFF);
        rdchk(iqs_pkg::ADDR_AOD_MASK, 16'hFFFF);
        rdchk(iqs_pkg::ADDR_CONTROL, 16'h0000);
        rdchk(iqs_pkg::ADDR_OUT_CTRL, 16'h0400);
    endtask

    initial begin
        fail_count = 0;
        check_count = 0;
        resetn = 1'b0;
        pol = 1'b1;
        evIn = '0;
        words = '{iqs_pkg::ADDR_STATUS3, iqs_pkg::ADDR_STATUS4, iqs_pkg::ADDR_STATUS5, iqs_pkg::ADDR_AOD_FLAGS};
        // source bit in the event vector (-1 = all low), status word, flags expected
        rows = '{'{21,0,16'h0008}, '{-1,0,16'h0008}, '{20,0,16'h0004}, '{-1,0,16'h0004},
                 '{19,0,16'h0002}, '{-1,0,16'h0000}, '{18,0,16'h0001}, '{-1,0,16'h0000},
                 '{17,1,16'h8000}, '{16,1,16'h4000}, '{15,1,16'h2000}, '{14,1,16'h1000},
                 '{13,1,16'h0800}, '{12,1,16'h0400}, '{11,1,16'h0000}, '{-1,1,16'h0200},
                 '{10,1,16'h0000}, '{-1,1,16'h0100}, '{9,1,16'h0080},  '{8,1,16'h0040},
                 '{7,2,16'h0100},  '{6,2,16'h0080},  '{5,2,16'h0040},  '{4,2,16'h0002},
                 '{-1,2,16'h0002}, '{3,2,16'h0001},  '{-1,2,16'h0001}, '{2,3,16'h0040},
                 '{-1,3,16'h0080}, '{1,3,16'h0010},  '{-1,3,16'h0020}, '{0,3,16'h0004},
                 '{-1,3,16'h0008}};
        do_reset();
        check_resets();
        $display("test reset_values done");
        foreach (rows[i]) begin
            evIn = (rows[i].b < 0) ? '0 : iqs_pkg::iqs_events_type'(22'h1 << rows[i].b);
            repeat (4) @(negedge core_clk);
            chk("request_out_first_r", {15'h0000, rows[i].w == 2 && rows[i].exp[8]},
                {15'h0000, request_out_first_r});
            for (int w = 0; w < 4; w++) begin
                rdchk(words[w], (w == rows[i].w) ? rows[i].exp : 16'h0000);
            end
            host.wr(words[rows[i].w], rows[i].exp);
        end
        $display("test event_table done");
        // a masked flag still latches but stays off the request until unmasked
        evIn.hostIfErr = 1'b1;
        repeat (4) @(negedge core_clk);
        rdchk(iqs_pkg::ADDR_STATUS4, 16'h0800);
        wait_req(1'b0);
        host.wr(iqs_pkg::ADDR_MASK4, 16'hF7FF);
        wait_req(1'b1);
        host.wr(iqs_pkg::ADDR_CONTROL, 16'h0001);
        wait_req(1'b0);
        host.wr(iqs_pkg::ADDR_CONTROL, 16'h0000);
        wait_req(1'b1);
        host.wr(iqs_pkg::ADDR_OUT_CTRL, 16'h0000);
        pol = 1'b0;
        wait_req(1'b1);
        host.wr(iqs_pkg::ADDR_STATUS4, 16'h0000);
        wait_req(1'b1);
        // source still high: clearing must not re-arm a rising-edge flag
        host.wr(iqs_pkg::ADDR_STATUS4, 16'h0800);
        wait_req(1'b0);
        $display("test mask_and_polarity done");
        evIn.dacServoDone = 1'b1;
        host.wr(iqs_pkg::ADDR_MASK5, 16'hFE7F);
        wait_req(1'b1);
        host.wr(iqs_pkg::ADDR_STATUS5, 16'h0080);
        wait_req(1'b0);
        // pin5 stays high across the reset below: release must not flag it
        host.wr(iqs_pkg::ADDR_AOD_MASK, 16'hFFEF);
        evIn.pin5 = 1'b1;
        wait_req(1'b1);
        rdchk(iqs_pkg::ADDR_AOD_FLAGS, 16'h0010);
        do_reset();
        check_resets();
        $display("test mid_run_reset done");
        test_done();
    end
endmodule // tb_iqs_irq_status
